/* inc/cfc_pkg.sv */
// Constants and register map of the CCD front-end control block.
package cfc_pkg;

   localparam int PIX_W = 10;
   localparam int WORD_W = 16;
   localparam int LATENCY = 9;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_W = 9 + PIX_W;

   // Serial word layout: select in [15:12], value in [9:0].
   localparam logic [3:0] SEL_GAIN = 4'h0;
   localparam logic [3:0] SEL_POL = 4'h1;
   localparam logic [3:0] SEL_MODE = 4'h2;
   localparam logic [3:0] SEL_CLAMP = 4'h3;
   localparam int SEL_LSB = 12;

   // Polarity bit positions; a set bit means active high.
   localparam int POL_REF = 0;
   localparam int POL_DATA = 1;
   localparam int POL_DUMMY = 2;
   localparam int POL_BLACK = 3;

   localparam logic [9:0] GAIN_RST = 10'h080;
   localparam logic [3:0] POL_RST = 4'h0;
   localparam logic STANDBY_RST = 1'b0;
   localparam logic [3:0] CLAMP_RST = 4'h8;
   localparam logic CAP_EN_RST = 1'b0;

   // APB byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_SHIFT = 8'h0c;
   localparam logic [7:0] OFS_PIXEL = 8'h10;

   localparam int STAT_OVF = 0;
   localparam int STAT_LVL_LSB = 8;
   localparam int PIX_VALID_BIT = 31;

endpackage : cfc_pkg

/* core/cfc_sync.sv */
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module cfc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Pins
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } cfc_sync_type;

   cfc_sync_type r;
   cfc_sync_type n;

   always_comb begin
      n.s1 = async_i;
      n.s2 = r.s1;
      if (!reset_n_i) begin
         n = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      r <= n;
   end

   assign sync_o = r.s2;

endmodule : cfc_sync

/* core/cfc_fifo.sv */
// Small FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cfc_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o,
   output logic      [3:0]       level_o
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } cfc_fifo_type;

   cfc_fifo_type r;
   cfc_fifo_type n;
   logic         push;
   logic         pop;

   assign in_ready_o = (r.cnt != DEPTH[AW:0]);
   assign out_valid_o = (r.cnt != '0);
   assign out_data_o = r.mem[r.rp];
   assign level_o = 4'(r.cnt);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wp] = in_data_i;
         n.wp = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (!reset_n_i) begin
         n = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      r <= n;
   end

endmodule : cfc_fifo

/* core/cfc_frontend_control.sv */
// Digital control of a CCD front end: serial port, pulse decode, output path, APB.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module cfc_frontend_control
   import cfc_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // Timing generator pulses
   input  wire logic             ref_sample_pulse_i,
   input  wire logic             data_sample_pulse_i,
   input  wire logic             dummy_clamp_pulse_i,
   input  wire logic             black_clamp_pulse_i,
   input  wire logic             preblank_n_i,
   input  wire logic             conv_clock_i,
   // Digitised sensor level
   input  wire logic [PIX_W-1:0] sensor_input_i,
   // Serial write port
   input  wire logic             serial_load_i,
   input  wire logic             serial_in_i,
   input  wire logic             serial_clk_i,
   // Pixel output and analog controls
   output logic      [PIX_W-1:0] pixel_o,
   output logic      [9:0]       gain_code_o,
   output logic      [3:0]       black_level_o,
   output logic                  standby_o,
   output logic                  dummy_clamp_en_o,
   output logic                  black_clamp_en_o,
   // APB slave
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [7:0]       paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o
);

   typedef struct packed {
      logic [WORD_W-1:0]           shift;
      logic [WORD_W-1:0]           last_word;
      logic [9:0]                  gain;
      logic [3:0]                  pol;
      logic                        standby;
      logic [3:0]                  clamp;
      logic [PIX_W-1:0]            ref_hold;
      logic [PIX_W-1:0]            pixel;
      logic [LATENCY-2:0][PIX_W-1:0] pipe;
      logic [PIX_W-1:0]            out;
      logic                        ref_act;
      logic                        data_act;
      logic                        sclk;
      logic                        load;
      logic                        conv;
      logic                        dclamp;
      logic                        bclamp;
      logic                        cap_en;
      logic                        ovf;
      logic [31:0]                 prdata;
      logic [1:0]                  warm;
   } cfc_main_type;

   cfc_main_type r;
   cfc_main_type n;

   logic [SYNC_W-1:0] pins;
   logic [PIX_W-1:0]  lvl_s;
   logic              ref_s;
   logic              data_s;
   logic              dummy_s;
   logic              black_s;
   logic              preblank_s;
   logic              sclk_s;
   logic              sin_s;
   logic              load_s;
   logic              conv_s;
   logic              ref_act;
   logic              data_act;
   logic              dummy_act;
   logic              black_act;
   logic              sclk_rise;
   logic              load_rise;
   logic              conv_rise;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [PIX_W-1:0]  fifo_out_data;
   logic [3:0]        fifo_level;
   logic              fifo_push;
   logic              fifo_pop;
   logic              apb_setup;
   logic              apb_access;
   logic              addr_ok;
   logic              settled;
   logic              ref_fall;
   logic              data_fall;

   // Every pin, the sensor level included, comes from another domain.
   cfc_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({sensor_input_i, conv_clock_i, serial_clk_i, serial_in_i, serial_load_i,
                   preblank_n_i, black_clamp_pulse_i, dummy_clamp_pulse_i,
                   data_sample_pulse_i, ref_sample_pulse_i}),
      .sync_o    (pins)
   );

   assign ref_s = pins[0];
   assign data_s = pins[1];
   assign dummy_s = pins[2];
   assign black_s = pins[3];
   assign preblank_s = pins[4];
   assign load_s = pins[5];
   assign sin_s = pins[6];
   assign sclk_s = pins[7];
   assign conv_s = pins[8];
   assign lvl_s = pins[SYNC_W-1:9];

   // A cleared polarity bit makes the pulse active low.
   assign ref_act = ref_s ~^ r.pol[POL_REF];
   assign data_act = data_s ~^ r.pol[POL_DATA];
   assign dummy_act = dummy_s ~^ r.pol[POL_DUMMY];
   assign black_act = black_s ~^ r.pol[POL_BLACK];

   // The synchronisers leave reset at zero, not at the pins' idle levels, so every edge detector
   // stays blind until they have refilled; a phantom load edge would otherwise wipe the gain.
   assign settled = &r.warm;
   assign sclk_rise = sclk_s && !r.sclk && settled;
   assign load_rise = load_s && !r.load && settled;
   assign conv_rise = conv_s && !r.conv && settled;
   assign ref_fall = r.ref_act && !ref_act && settled;
   assign data_fall = r.data_act && !data_act && settled;

   assign apb_setup = psel_i && !penable_i;
   assign apb_access = psel_i && penable_i;
   assign addr_ok = (paddr_i == OFS_CTRL) || (paddr_i == OFS_STATUS) || (paddr_i == OFS_CONFIG) ||
                    (paddr_i == OFS_SHIFT) || (paddr_i == OFS_PIXEL);

   // Capture drops the word when the FIFO is full; the lost word is flagged.
   assign fifo_push = conv_rise && r.cap_en;
   assign fifo_pop = apb_access && !pwrite_i && (paddr_i == OFS_PIXEL);

   cfc_fifo #(
      .WIDTH (PIX_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (fifo_push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (n.out),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data),
      .level_o     (fifo_level)
   );

   always_comb begin
      n = r;
      n.ref_act = ref_act;
      n.data_act = data_act;
      n.sclk = sclk_s;
      n.load = load_s;
      n.conv = conv_s;
      if (!settled) begin
         n.warm = r.warm + 2'h1;
      end

      // Shifting only while load is low; older bits fall off the top.
      if (sclk_rise && !load_s) begin
         n.shift = {r.shift[WORD_W-2:0], sin_s};
      end

      // The word takes effect on the load edge.
      if (load_rise) begin
         n.last_word = r.shift;
         case (r.shift[WORD_W-1:SEL_LSB])
            SEL_GAIN: begin
               n.gain = r.shift[9:0];
            end
            SEL_POL: begin
               n.pol = r.shift[3:0];
            end
            SEL_MODE: begin
               n.standby = r.shift[0];
            end
            SEL_CLAMP: begin
               n.clamp = r.shift[3:0];
            end
            default: begin
               n.gain = r.gain;
            end
         endcase
      end

      // Hold the level at each sample pulse's trailing edge; the data level is held minus the reference, clipped at zero.
      if (ref_fall) begin
         n.ref_hold = lvl_s;
      end
      if (data_fall) begin
         n.pixel = (lvl_s >= r.ref_hold) ? lvl_s - r.ref_hold : '0;
      end

      n.dclamp = dummy_act && ref_act && preblank_s;
      n.bclamp = black_act && preblank_s;

      // Eight pipe stages and the output register make nine conversion edges in all.
      if (conv_rise) begin
         n.pipe = {r.pipe[LATENCY-3:0], r.pixel};
         n.out = (preblank_s && !r.standby) ? r.pipe[LATENCY-2] : '0;
      end
      if (fifo_push && !fifo_in_ready) begin
         n.ovf = 1'b1;
      end

      // Read data are registered in the setup cycle.
      if (apb_setup) begin
         case (paddr_i)
            OFS_CTRL: n.prdata = {31'h0, r.cap_en};
            OFS_STATUS: n.prdata = {20'h0, fifo_level, 4'h0, r.standby, preblank_s, 1'b0, r.ovf};
            OFS_CONFIG: n.prdata = {13'h0, r.clamp, r.standby, r.pol, r.gain};
            OFS_SHIFT: n.prdata = {r.last_word, r.shift};
            OFS_PIXEL: n.prdata = {fifo_out_valid, 21'h0, fifo_out_data};
            default: n.prdata = 32'h0;
         endcase
      end

      if (apb_access && pwrite_i) begin
         if (paddr_i == OFS_CTRL) begin
            n.cap_en = pwdata_i[0];
         end
         // An overflow in the same cycle as the clear wins.
         if (paddr_i == OFS_STATUS && pwdata_i[STAT_OVF] && !(fifo_push && !fifo_in_ready)) begin
            n.ovf = 1'b0;
         end
      end

      if (!reset_n_i) begin
         n = '0;
         n.gain = GAIN_RST;
         n.pol = POL_RST;
         n.standby = STANDBY_RST;
         n.clamp = CLAMP_RST;
         n.cap_en = CAP_EN_RST;
      end
   end

   always_ff @(posedge clk_i) begin
      r <= n;
   end

   assign pixel_o = r.out;
   assign gain_code_o = r.gain;
   assign black_level_o = r.clamp;
   assign standby_o = r.standby;
   assign dummy_clamp_en_o = r.dclamp;
   assign black_clamp_en_o = r.bclamp;
   assign prdata_o = r.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = apb_access && !addr_ok;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_SHIFT_IN: assert property (
      (sclk_rise && !load_s) |=> (r.shift[0] == $past(sin_s)))
      else $error("serial bit not shifted in");

   AST_SHIFT_HOLD: assert property (
      load_s |=> (r.shift == $past(r.shift)))
      else $error("shift register moved while load high");

   AST_LOAD_LATCH: assert property (
      load_rise |=> (r.last_word == $past(r.shift)))
      else $error("word not latched on load edge");

   AST_GAIN_WRITE: assert property (
      (load_rise && r.shift[WORD_W-1:SEL_LSB] == SEL_GAIN) |=> (gain_code_o == $past(r.shift[9:0])))
      else $error("gain not updated");

   AST_RESET_DEF: assert property (
      disable iff (1'b0) !reset_n_i |=> (gain_code_o == GAIN_RST && r.pol == POL_RST && !standby_o))
      else $error("defaults not restored by reset");

   AST_REF_HOLD: assert property (
      ref_fall |=> (r.ref_hold == $past(lvl_s)))
      else $error("reference not held at trailing edge");

   AST_DUMMY_CLAMP: assert property (
      dummy_clamp_en_o |-> $past(dummy_act && ref_act))
      else $error("dummy clamp without both pulses active");

   AST_BLACK_CLAMP: assert property (
      (black_act && preblank_s) |=> black_clamp_en_o)
      else $error("black clamp not following pulse");

   AST_LATENCY: assert property (
      conv_rise && preblank_s && !r.standby |=> (pixel_o == $past(r.pipe[LATENCY-2])))
      else $error("output stage not fed from last pipe stage");

   AST_PREBLANK: assert property (
      (conv_rise && !preblank_s) |=> (pixel_o == '0))
      else $error("output not forced to zero");

   AST_OUT_EDGE: assert property (
      !conv_rise |=> $stable(pixel_o))
      else $error("output changed without conversion edge");

   AST_DATA_HOLD: assert property (
      (data_fall && !ref_fall && lvl_s >= r.ref_hold) |=> (r.pixel + r.ref_hold == $past(lvl_s)))
      else $error("pixel is not data level minus reference");

   AST_DATA_CLIP: assert property (
      (data_fall && lvl_s < r.ref_hold) |=> (r.pixel == '0))
      else $error("pixel below reference not clipped");

   AST_POL_WRITE: assert property (
      (load_rise && r.shift[WORD_W-1:SEL_LSB] == SEL_POL) |=> (r.pol == $past(r.shift[3:0])))
      else $error("polarity not updated");

   AST_MODE_WRITE: assert property (
      (load_rise && r.shift[WORD_W-1:SEL_LSB] == SEL_MODE) |=> (standby_o == $past(r.shift[0])))
      else $error("mode not updated");

   AST_CLAMP_WRITE: assert property (
      (load_rise && r.shift[WORD_W-1:SEL_LSB] == SEL_CLAMP) |=> (black_level_o == $past(r.shift[3:0])))
      else $error("black level not updated");

   AST_DUMMY_ON: assert property (
      (dummy_act && ref_act && preblank_s) |=> dummy_clamp_en_o)
      else $error("dummy clamp missing while both pulses active");

   AST_BLACK_OFF: assert property (
      !(black_act && preblank_s) |=> !black_clamp_en_o)
      else $error("black clamp without active pulse");

   AST_STANDBY_ZERO: assert property (
      (conv_rise && r.standby) |=> (pixel_o == '0))
      else $error("output not zero in standby");

   AST_OVF_SET: assert property (
      (fifo_push && !fifo_in_ready) |=> r.ovf)
      else $error("dropped word not flagged");

endmodule : cfc_frontend_control

/* test/cfc_tgen_model.sv */
// Behavioural camera timing generator and serial host that drive the front end's pins.
`timescale 1ns/1ps
module cfc_tgen_model
   import cfc_pkg::*;
(
   // Clock
   input  wire logic             clk_i,
   // Pulse pins
   output logic                  ref_sample_pulse_o,
   output logic                  data_sample_pulse_o,
   output logic                  dummy_clamp_pulse_o,
   output logic                  black_clamp_pulse_o,
   output logic                  conv_clock_o,
   output logic      [PIX_W-1:0] sensor_input_o,
   // Serial pins
   output logic                  serial_load_o,
   output logic                  serial_in_o,
   output logic                  serial_clk_o
);
   localparam logic [PIX_W-1:0] BASE = 10'h040;
   logic [2:0]       ph_r  = 3'h0;
   logic [3:0]       act_r = 4'h0;
   logic [PIX_W-1:0] val_r = 10'h000;
   logic             dum_r = 1'b0;
   logic             blk_r = 1'b0;

   initial begin
      {ref_sample_pulse_o, data_sample_pulse_o, dummy_clamp_pulse_o, black_clamp_pulse_o} = 4'hf;
      conv_clock_o = 1'b0;
      sensor_input_o = 10'h000;
      serial_load_o = 1'b1;
      serial_in_o = 1'b0;
      serial_clk_o = 1'b0;
   end

   // One pixel every eight cycles; the level is held one cycle past each trailing edge, then it toggles.
   always @(posedge clk_i) begin
      ph_r <= ph_r + 3'h1;
      conv_clock_o <= ph_r == 3'h7 || ph_r < 3'h3;
      if (ph_r == 3'h7) begin
         val_r <= val_r + 10'h003;
      end
      ref_sample_pulse_o <= act_r[POL_REF] ~^ (ph_r == 3'h7 || ph_r == 3'h0);
      data_sample_pulse_o <= act_r[POL_DATA] ~^ (ph_r == 3'h2 || ph_r == 3'h3);
      dummy_clamp_pulse_o <= act_r[POL_DUMMY] ~^ dum_r;
      black_clamp_pulse_o <= act_r[POL_BLACK] ~^ blk_r;
      case (ph_r)
         3'h7, 3'h0, 3'h1: sensor_input_o <= BASE;
         3'h2: sensor_input_o <= BASE + val_r;
         3'h5, 3'h6: sensor_input_o <= ~sensor_input_o;
         default: ;
      endcase
   end

   // Sends seventeen bits so that the leading one must be discarded.
   task automatic send(input logic [16:0] bits);
      serial_load_o <= 1'b0;
      // Each bit takes eight clocks, a serial clock period of 400 ns.
      for (int i = 16; i >= 0; i--) begin
         repeat (4) @(posedge clk_i);
         serial_clk_o <= 1'b0;
         serial_in_o <= bits[i];
         repeat (4) @(posedge clk_i);
         serial_clk_o <= 1'b1;
      end
      repeat (2) @(posedge clk_i);
      serial_load_o <= 1'b1;
      serial_in_o <= ~serial_in_o;
      repeat (2) @(posedge clk_i);
      serial_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : send
endmodule : cfc_tgen_model

/* test/tb_top.sv */
// Self-checking bench for the front-end control block.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("BAD %0t %h %h", $time, g, e); end end
module tb_top
   import cfc_pkg::*;
;
   logic             clk_i = 1'b0;
   logic             reset_n_i = 1'b0;
   logic             preblank_n = 1'b1;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0;
   logic [31:0]      prdata;
   logic [31:0]      rd;
   logic             pready, pslverr, serr, ref_p, dat_p, dum_p, blk_p, conv, serial_load, sin, sclk;
   logic             conv_q = 1'b0;
   logic             pix_on = 1'b0;
   logic [PIX_W-1:0] sens, pix;
   logic [PIX_W-1:0] hist [0:255];
   logic [9:0]       gain;
   logic [3:0]       blev;
   logic             stby, dum_en, blk_en;
   int               errors = 0;
   int               comparisons = 0;
   int               rc = 0;
   int               dly = 0;

   always #25 clk_i = ~clk_i;

   cfc_frontend_control cfc_frontend_control_inst (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ref_sample_pulse_i(ref_p), .data_sample_pulse_i(dat_p),
      .dummy_clamp_pulse_i(dum_p), .black_clamp_pulse_i(blk_p), .preblank_n_i(preblank_n),
      .conv_clock_i(conv), .sensor_input_i(sens), .serial_load_i(serial_load), .serial_in_i(sin),
      .serial_clk_i(sclk), .pixel_o(pix), .gain_code_o(gain), .black_level_o(blev), .standby_o(stby),
      .dummy_clamp_en_o(dum_en), .black_clamp_en_o(blk_en), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr));

   cfc_tgen_model cfc_tgen_model_inst (
      .clk_i(clk_i), .ref_sample_pulse_o(ref_p), .data_sample_pulse_o(dat_p),
      .dummy_clamp_pulse_o(dum_p), .black_clamp_pulse_o(blk_p), .conv_clock_o(conv),
      .sensor_input_o(sens), .serial_load_o(serial_load), .serial_in_o(sin), .serial_clk_o(sclk));

   // Each word formed after a conversion rise must show up nine rises later.
   always @(posedge clk_i) begin
      conv_q <= conv;
      if (conv && !conv_q) begin
         hist[rc[7:0]] = cfc_tgen_model_inst.val_r;
         rc++;
         dly = 5;
      end else if (dly > 0) begin
         dly--;
         if (dly == 1 && pix_on) `CHK(pix, hist[8'(rc - 10)])
      end
   end

   task automatic close_out();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         close_out();
      end
      @(posedge clk_i);
   endtask : apb

   task automatic periods(input int n);
      repeat (8 * n) @(posedge clk_i);
   endtask : periods

   // Counts clamp-enable cycles over two pixel periods.
   task automatic meas(input logic [4:0] de, input logic [4:0] be);
      logic [4:0] d;
      logic [4:0] b;
      d = 5'h00;
      b = 5'h00;
      repeat (16) begin
         @(posedge clk_i);
         d += 5'(dum_en);
         b += 5'(blk_en);
      end
      `CHK(d, de)
      `CHK(b, be)
   endtask : meas

   initial begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(gain, GAIN_RST)
      `CHK(blev, CLAMP_RST)
      `CHK(stby, STANDBY_RST)
      apb(1'b0, OFS_CONFIG, 32'h0);
      `CHK(rd, {13'h0, CLAMP_RST, STANDBY_RST, POL_RST, GAIN_RST})
      apb(1'b0, 8'h20, 32'h0);
      `CHK(serr, 1'b1)
      `CHK(rd, 32'h0)
      periods(12);
      pix_on = 1'b1;
      cfc_tgen_model_inst.dum_r <= 1'b1;
      cfc_tgen_model_inst.blk_r <= 1'b1;
      periods(12);
      meas(5'h04, 5'h10);
      pix_on = 1'b0;
      cfc_tgen_model_inst.send({1'b0, SEL_POL, 8'h00, 4'hf});
      cfc_tgen_model_inst.act_r <= 4'hf;
      periods(12);
      pix_on = 1'b1;
      meas(5'h04, 5'h10);
      apb(1'b0, OFS_CONFIG, 32'h0);
      `CHK(rd[13:10], 4'hf)
      periods(12);
      cfc_tgen_model_inst.send({1'b1, SEL_GAIN, 2'b00, 10'h155});
      `CHK(gain, 10'h155)
      cfc_tgen_model_inst.send({1'b1, SEL_CLAMP, 8'h00, 4'h3});
      `CHK(blev, 4'h3)
      apb(1'b0, OFS_SHIFT, 32'h0);
      `CHK(rd, {SEL_CLAMP, 8'h00, 4'h3, SEL_CLAMP, 8'h00, 4'h3})
      pix_on = 1'b0;
      preblank_n <= 1'b0;
      periods(2);
      `CHK(pix, 10'h000)
      meas(5'h00, 5'h00);
      preblank_n <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h1);
      periods(12);
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[11:8], 4'h8)
      `CHK(rd[STAT_OVF], 1'b1)
      repeat (8) begin
         apb(1'b0, OFS_PIXEL, 32'h0);
         `CHK(rd[PIX_VALID_BIT], 1'b1)
      end
      apb(1'b0, OFS_PIXEL, 32'h0);
      `CHK(rd[PIX_VALID_BIT], 1'b0)
      apb(1'b1, OFS_STATUS, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[STAT_OVF], 1'b0)
      cfc_tgen_model_inst.send({1'b1, SEL_MODE, 12'h001});
      `CHK(stby, 1'b1)
      periods(2);
      `CHK(pix, 10'h000)
      cfc_tgen_model_inst.send({1'b0, SEL_MODE, 12'h000});
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      cfc_tgen_model_inst.act_r <= 4'h0;
      repeat (3) @(posedge clk_i);
      `CHK(gain, GAIN_RST)
      apb(1'b0, OFS_CONFIG, 32'h0);
      `CHK(rd, {13'h0, CLAMP_RST, STANDBY_RST, POL_RST, GAIN_RST})
      close_out();
   end
endmodule : tb_top
